// >>> fdsr_drive_decode.sv
// Binary drive number to active-low one-of-four drive select decode.
`timescale 1ns/100ps
module fdsr_drive_decode (
  // Drive number
  input  wire logic [1:0] drive_num,
  // Active-low selects
  output logic      [3:0] select_n
);

  always_comb begin
    select_n = 4'hF;
    select_n[drive_num] = 1'b0;
  end

endmodule

// >>> fdsr_drive_model.sv
// Floppy drive model: static drive pins and read data pulses.
`timescale 1ns/100ps
module fdsr_drive_model (
  // Clock
  input  wire logic       ref_clk,
  // Bench commands
  input  wire logic [3:0] pins_n,
  input  wire logic       rd_pulse,
  // Drive pins
  output logic            second_drive_present_n,
  output logic            track_zero_n,
  output logic            index_pulse_n,
  output logic            write_protect_n,
  output logic            read_data_n
);
  initial begin
    {second_drive_present_n, track_zero_n, index_pulse_n, write_protect_n, read_data_n} = 5'h1F;
  end
  // Pins move on the clock edge, one cycle behind the bench command.
  always @(posedge ref_clk) begin
    {second_drive_present_n, track_zero_n, index_pulse_n, write_protect_n} <= pins_n;
    read_data_n <= !rd_pulse;
  end
endmodule

// >>> fdsr_pkg.sv
// Constants, field positions and mode codes for the floppy status and output register bank.
package fdsr_pkg;

  // Host I/O offsets, primary base.
  localparam logic [15:0] OFF_STATUS_FIRST  = 16'h03F0;
  localparam logic [15:0] OFF_STATUS_SECOND = 16'h03F1;
  localparam logic [15:0] OFF_OUTPUT_CTRL   = 16'h03F2;
  localparam logic [15:0] OFF_DIGITAL_INPUT = 16'h03F7;

  // Output control register fields.
  localparam int          DOC_SEL_LSB   = 0;
  localparam int          DOC_SEL_MSB   = 1;
  localparam int          DOC_RESET_N   = 2;
  localparam int          DOC_DMA_EN    = 3;
  localparam int          DOC_MOTOR_LSB = 4;
  localparam int          DOC_MOTOR_MSB = 7;
  localparam logic [7:0]  DOC_RESET_VAL = 8'h00;

  // Second status register, full mode, constant high bits.
  localparam logic [1:0]  SECOND_FULL_HI = 2'h3;

  // Shortest soft reset the core accepts.
  localparam int          SOFT_RESET_MIN_NS = 100;
  localparam int          CLK_PERIOD_NS     = 8;
  localparam int          SOFT_RESET_CYCLES =
    (SOFT_RESET_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // Status register compatibility modes.
  typedef enum logic [1:0] {
    FDSR_MODE_LEGACY = 2'b00,
    FDSR_MODE_FULL   = 2'b01,
    FDSR_MODE_ALT    = 2'b10
  } fdsr_mode_e;

endpackage

// >>> fdsr_regs.sv
// Floppy status registers and output control register on the byte-wide host I/O port.
// Functional notes
// - Legacy mode: reads of both status addresses leave the data bus undriven.
// - Status registers are readable anytime in status modes; writes do nothing.
// - First status, full mode: irq, drive2_n, step, track0_n, head, index_n, wp_n, dir.
// - First status, alt mode: irq, drq, step latch, track0, head_n, index, wp, dir_n.
// - Alt step latch sets on step rising; cleared by input register read or reset.
// - First status reset values: full clears 7,5,3,0; alt clears 7,6,5, sets 3,0.
// - Second status full: bits 7,6 high, drive-select-0 mirror, write gate, motors.
// - Full mode: bit 3 toggles on read data, bit 4 on write data inactive edges.
// - Full mode motor and select mirrors clear on hard reset, survive soft reset.
// - Second status alt: drive2_n, active-low selects, latched data and gate flags.
// - Alt flags latch on gate rise and inactive data edges; input register read clears.
// - Output control register is read/write anytime, zero on hard reset, kept on soft.
// - Output register bits 1:0 select exactly one of four drive selects.
// - Bit 2 low holds the controller in reset; pulse is stretched to 100 ns.
// - Legacy and alt: bit 3 enables DMA and interrupt pins, else tri-stated, ignored.
// - Full mode: DMA and interrupt pins always enabled, even in reset.
// - Output register bits 4 to 7 drive motor-on outputs of drives 0 to 3.
`timescale 1ns/100ps
module fdsr_regs #(
  parameter logic [15:0] BASE_OFFSET = fdsr_pkg::OFF_STATUS_FIRST
) (
  // Clock and reset
  input  wire logic                 ref_clk,
  input  wire logic                 reset,
  // Mode selection
  input  wire fdsr_pkg::fdsr_mode_e status_mode,
  // Host I/O port
  input  wire logic [15:0]          io_addr,
  input  wire logic                 io_read_n,
  input  wire logic                 io_write_n,
  input  wire logic [7:0]           io_data_in,
  output logic      [7:0]           io_data_out,
  output logic                      io_data_oe,
  // Drive interface inputs, asynchronous
  input  wire logic                 second_drive_present_n,
  input  wire logic                 track_zero_n,
  input  wire logic                 index_pulse_n,
  input  wire logic                 write_protect_n,
  input  wire logic                 read_data_n,
  // Controller core state
  input  wire logic                 core_irq,
  input  wire logic                 core_dma_req,
  input  wire logic                 core_step,
  input  wire logic                 core_direction_in,
  input  wire logic                 head_side_select,
  input  wire logic                 write_gate_out,
  input  wire logic                 core_write_data,
  // DMA handshake pins from host
  input  wire logic                 dma_ack_n,
  input  wire logic                 dma_tc,
  // Drive outputs
  output logic      [3:0]           drive_select_out_n,
  output logic      [3:0]           motor_on_out_n,
  // Controller and system pins
  output logic                      soft_reset_n,
  output logic                      dma_irq_enable,
  output logic                      floppy_irq_out,
  output logic                      floppy_irq_oe,
  output logic                      dma_req_out,
  output logic                      dma_req_oe,
  output logic                      dma_ack_n_gated,
  output logic                      dma_tc_gated
);
  import fdsr_pkg::*;

  localparam logic [15:0] REL_FIRST  = OFF_STATUS_FIRST - OFF_STATUS_FIRST;
  localparam logic [15:0] REL_SECOND = OFF_STATUS_SECOND - OFF_STATUS_FIRST;
  localparam logic [15:0] REL_OUTPUT = OFF_OUTPUT_CTRL - OFF_STATUS_FIRST;
  localparam logic [15:0] REL_DIGIN  = OFF_DIGITAL_INPUT - OFF_STATUS_FIRST;
  localparam logic [4:0]  STRETCH    = 5'(SOFT_RESET_CYCLES);

  if (SOFT_RESET_CYCLES < 1 || SOFT_RESET_CYCLES > 31) begin : g_chk
    $error("Soft reset stretch does not fit its counter.");
  end
  if (BASE_OFFSET[2:0] != 3'h0) begin : g_chk_base
    $error("Base offset must be aligned to eight.");
  end

  logic [7:0]  output_ctrl;
  logic [4:0]  stretch_cnt;
  logic        core_in_reset;
  logic        read_q;
  logic        write_q;
  logic        read_start;
  logic        write_start;
  logic [15:0] rel_addr;
  logic        digin_read;
  logic [4:0]  pins_sync;
  logic        drive2_n_s;
  logic        track0_n_s;
  logic        index_n_s;
  logic        wp_n_s;
  logic        rdata_n_s;
  logic        rdata_n_q;
  logic        wdata_q;
  logic        step_q;
  logic        write_gate_out_q;
  logic        rdata_end;
  logic        wdata_end;
  logic        step_rise;
  logic        write_gate_out_rise;
  logic        rdata_toggle;
  logic        wdata_toggle;
  logic        step_latch;
  logic        rdata_flag;
  logic        wdata_flag;
  logic        write_gate_out_flag;
  logic        g_irq;
  logic        g_drq;
  logic        g_step;
  logic        g_dir;
  logic        g_head;
  logic        g_write_gate_out;
  logic        pins_enabled;
  logic [3:0]  next_select_n;
  logic [7:0]  first_full;
  logic [7:0]  first_alt;
  logic [7:0]  second_full;
  logic [7:0]  second_alt;
  logic [7:0]  next_data;
  logic        next_oe;

  // Host strobes are level signals; act once per access on the leading edge.
  assign rel_addr    = io_addr - BASE_OFFSET;
  assign read_start  = !io_read_n && read_q;
  assign write_start = !io_write_n && write_q;
  assign digin_read  = read_start && (rel_addr == REL_DIGIN);

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      read_q  <= 1'b1;
      write_q <= 1'b1;
    end else begin
      read_q  <= io_read_n;
      write_q <= io_write_n;
    end
  end

  fdsr_sync #(
    .WIDTH     (5),
    .RESET_VAL (5'h1F)
  ) u_pin_sync (
    .ref_clk   (ref_clk),
    .reset     (reset),
    .pin_async ({second_drive_present_n, track_zero_n, index_pulse_n,
                 write_protect_n, read_data_n}),
    .pin_sync  (pins_sync)
  );

  assign drive2_n_s = pins_sync[4];
  assign track0_n_s = pins_sync[3];
  assign index_n_s  = pins_sync[2];
  assign wp_n_s     = pins_sync[1];
  assign rdata_n_s  = pins_sync[0];

  // Output control register; soft reset never touches it.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      output_ctrl <= DOC_RESET_VAL;
    end else if (write_start && rel_addr == REL_OUTPUT) begin
      output_ctrl <= io_data_in;
    end
  end

  // Back-to-back writes may clear bit 2 for only a few cycles, so the reset is stretched.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stretch_cnt   <= STRETCH;
      core_in_reset <= 1'b1;
    end else begin
      if (!output_ctrl[DOC_RESET_N]) begin
        stretch_cnt <= STRETCH;
      end else if (stretch_cnt != 5'h00) begin
        stretch_cnt <= stretch_cnt - 5'h01;
      end
      core_in_reset <= !output_ctrl[DOC_RESET_N] || (stretch_cnt > 5'h01);
    end
  end

  // Core state reads as its reset value while the core is held in reset.
  assign g_irq   = core_irq && !core_in_reset;
  assign g_drq   = core_dma_req && !core_in_reset;
  assign g_step  = core_step && !core_in_reset;
  assign g_dir   = core_direction_in && !core_in_reset;
  assign g_head  = head_side_select && !core_in_reset;
  assign g_write_gate_out = write_gate_out && !core_in_reset;

  // The read data edge detector looks only at the second synchroniser stage; the others watch core signals.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_n_q <= 1'b1;
      wdata_q   <= 1'b0;
      step_q    <= 1'b0;
      write_gate_out_q   <= 1'b0;
    end else begin
      rdata_n_q <= rdata_n_s;
      wdata_q   <= core_write_data;
      step_q    <= g_step;
      write_gate_out_q   <= g_write_gate_out;
    end
  end

  assign rdata_end  = rdata_n_s && !rdata_n_q;
  assign wdata_end  = !core_write_data && wdata_q;
  assign step_rise  = g_step && !step_q;
  assign write_gate_out_rise = g_write_gate_out && !write_gate_out_q;

  // Toggle bits of the full layout.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_toggle <= 1'b0;
      wdata_toggle <= 1'b0;
    end else begin
      if (rdata_end) begin
        rdata_toggle <= !rdata_toggle;
      end
      if (wdata_end) begin
        wdata_toggle <= !wdata_toggle;
      end
    end
  end

  // Latched step; a new step in the clearing cycle wins.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      step_latch <= 1'b0;
    end else if (step_rise) begin
      step_latch <= 1'b1;
    end else if (digin_read || core_in_reset) begin
      step_latch <= 1'b0;
    end
  end

  // Latched flags of the alternate layout; write data is not qualified by write gate.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      rdata_flag <= 1'b0;
      wdata_flag <= 1'b0;
      write_gate_out_flag <= 1'b0;
    end else begin
      if (rdata_end) begin
        rdata_flag <= 1'b1;
      end else if (digin_read) begin
        rdata_flag <= 1'b0;
      end
      if (wdata_end) begin
        wdata_flag <= 1'b1;
      end else if (digin_read) begin
        wdata_flag <= 1'b0;
      end
      if (write_gate_out_rise) begin
        write_gate_out_flag <= 1'b1;
      end else if (digin_read) begin
        write_gate_out_flag <= 1'b0;
      end
    end
  end

  fdsr_drive_decode u_decode (
    .drive_num (output_ctrl[DOC_SEL_MSB:DOC_SEL_LSB]),
    .select_n  (next_select_n)
  );

  // Status layouts.
  assign first_full  = {g_irq, drive2_n_s, g_step, track0_n_s,
                        g_head, index_n_s, wp_n_s, g_dir};
  assign first_alt   = {g_irq, g_drq, step_latch, !track0_n_s,
                        !g_head, !index_n_s, !wp_n_s, !g_dir};
  assign second_full = {SECOND_FULL_HI, output_ctrl[DOC_SEL_LSB], wdata_toggle,
                        rdata_toggle, g_write_gate_out,
                        output_ctrl[DOC_MOTOR_LSB + 1],
                        output_ctrl[DOC_MOTOR_LSB]};
  assign second_alt  = {drive2_n_s, drive_select_out_n[1], drive_select_out_n[0],
                        wdata_flag, rdata_flag, write_gate_out_flag,
                        drive_select_out_n[3], drive_select_out_n[2]};

  // Read mux; unmapped addresses and legacy status reads leave the bus undriven.
  always_comb begin
    next_data = 8'h00;
    next_oe   = 1'b0;
    if (!io_read_n) begin
      unique case (rel_addr)
        REL_FIRST: begin
          if (status_mode == FDSR_MODE_FULL) begin
            next_data = first_full;
            next_oe   = 1'b1;
          end else if (status_mode == FDSR_MODE_ALT) begin
            next_data = first_alt;
            next_oe   = 1'b1;
          end
        end
        REL_SECOND: begin
          if (status_mode == FDSR_MODE_FULL) begin
            next_data = second_full;
            next_oe   = 1'b1;
          end else if (status_mode == FDSR_MODE_ALT) begin
            next_data = second_alt;
            next_oe   = 1'b1;
          end
        end
        REL_OUTPUT: begin
          next_data = output_ctrl;
          next_oe   = 1'b1;
        end
        default: begin
          next_data = 8'h00;
          next_oe   = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      io_data_out <= 8'h00;
      io_data_oe  <= 1'b0;
    end else begin
      io_data_out <= next_data;
      io_data_oe  <= next_oe;
    end
  end

  // Full mode keeps the DMA and interrupt pins alive regardless of bit 3.
  assign pins_enabled = (status_mode == FDSR_MODE_FULL) ||
                        output_ctrl[DOC_DMA_EN];

  // Drive and system pins; all registered.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      drive_select_out_n <= 4'hF;
      motor_on_out_n     <= 4'hF;
      soft_reset_n       <= 1'b0;
      floppy_irq_out     <= 1'b0;
      dma_req_out        <= 1'b0;
    end else begin
      drive_select_out_n <= next_select_n;
      motor_on_out_n     <= ~output_ctrl[DOC_MOTOR_MSB:DOC_MOTOR_LSB];
      soft_reset_n       <= !core_in_reset;
      floppy_irq_out     <= g_irq;
      dma_req_out        <= g_drq;
    end
  end

  // Full mode must keep these pins live through a hard reset, so they keep clocking then.
  // The register clear still drops bit 3 at once; the pins are unknown until the first clock edge.
  always_ff @(posedge ref_clk) begin
    dma_irq_enable  <= pins_enabled;
    floppy_irq_oe   <= pins_enabled;
    dma_req_oe      <= pins_enabled;
    dma_ack_n_gated <= dma_ack_n || !pins_enabled;
    dma_tc_gated    <= dma_tc && pins_enabled;
  end

endmodule

// >>> fdsr_regs_assertions.sv
// Concurrent checks on the host port and drive outputs of the register bank.
`timescale 1ns/100ps
module fdsr_regs_assertions (
  // Clock and reset
  input wire logic                 ref_clk,
  input wire logic                 reset,
  // Host port
  input wire fdsr_pkg::fdsr_mode_e status_mode,
  input wire logic [15:0]          io_addr,
  input wire logic                 io_read_n,
  input wire logic                 io_write_n,
  input wire logic [7:0]           io_data_in,
  input wire logic [7:0]           io_data_out,
  input wire logic                 io_data_oe,
  // Drive and system pins
  input wire logic [3:0]           drive_select_out_n,
  input wire logic [3:0]           motor_on_out_n,
  input wire logic                 soft_reset_n,
  input wire logic                 dma_irq_enable,
  input wire logic                 floppy_irq_oe,
  input wire logic                 dma_req_oe,
  input wire logic                 dma_ack_n_gated,
  input wire logic                 dma_tc_gated
);
  import fdsr_pkg::*;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (reset);
  logic       wr_n_q;
  logic [7:0] doc_q;
  logic [7:0] doc_d1;
  logic [4:0] low_cnt;
  wire        wr_go = !io_write_n && wr_n_q;
  wire        rd_go = !io_read_n;
  // The counter saturates so a long soft reset cannot wrap it below the bound.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      wr_n_q  <= 1'b1;
      doc_q   <= DOC_RESET_VAL;
      doc_d1  <= DOC_RESET_VAL;
      low_cnt <= 5'h00;
    end else begin
      wr_n_q <= io_write_n;
      doc_d1 <= doc_q;
      if (wr_go && io_addr == OFF_OUTPUT_CTRL) begin
        doc_q <= io_data_in;
      end
      if (soft_reset_n) begin
        low_cnt <= 5'h00;
      end else if (low_cnt != 5'h1F) begin
        low_cnt <= low_cnt + 5'h01;
      end
    end
  end
  legacy_hiz_a: assert property (
    rd_go && status_mode == FDSR_MODE_LEGACY && io_addr[15:1] == OFF_STATUS_FIRST[15:1] |=> !io_data_oe)
    else $error("legacy status read drove the bus");
  second_full_a: assert property (
    rd_go && status_mode == FDSR_MODE_FULL && io_addr == OFF_STATUS_SECOND |=> io_data_oe
    && io_data_out[7:5] == {SECOND_FULL_HI, doc_d1[0]} && io_data_out[1:0] == doc_d1[5:4])
    else $error("second status mirror bits wrong");
  ctrl_read_a: assert property (
    rd_go && io_addr == OFF_OUTPUT_CTRL |=> io_data_oe && io_data_out == doc_d1)
    else $error("output register read back wrong");
  drive_decode_a: assert property (
    wr_go && io_addr == OFF_OUTPUT_CTRL |-> ##2 drive_select_out_n == ~(4'h1 << doc_q[1:0])
    && motor_on_out_n == ~doc_q[7:4]) else $error("drive outputs do not follow register");
  soft_enter_a: assert property (
    wr_go && io_addr == OFF_OUTPUT_CTRL && !io_data_in[DOC_RESET_N] |-> ##3 !soft_reset_n)
    else $error("soft reset not entered");
  soft_hold_a: assert property (
    $rose(soft_reset_n) |-> low_cnt >= 5'(SOFT_RESET_CYCLES)) else $error("soft reset too short");
  full_pins_a: assert property (
    status_mode == FDSR_MODE_FULL && $past(status_mode) == FDSR_MODE_FULL
    |-> floppy_irq_oe && dma_req_oe) else $error("full mode DMA pins disabled");
  dma_off_a: assert property (
    status_mode != FDSR_MODE_FULL && $stable(status_mode) && !doc_d1[DOC_DMA_EN]
    |-> !dma_irq_enable && !floppy_irq_oe && !dma_req_oe && dma_ack_n_gated && !dma_tc_gated)
    else $error("DMA pins active");
  cover property (rd_go && status_mode == FDSR_MODE_ALT && io_addr == OFF_STATUS_FIRST);
  cover property (rd_go && status_mode == FDSR_MODE_LEGACY && io_addr == OFF_STATUS_SECOND);
  cover property ($rose(soft_reset_n));
endmodule

// >>> fdsr_sync.sv
// Two-stage synchroniser for a group of asynchronous drive interface pins.
`timescale 1ns/100ps
module fdsr_sync #(
  parameter int WIDTH = 5,
  parameter logic [WIDTH-1:0] RESET_VAL = '1
) (
  // Clock and reset
  input  wire logic             ref_clk,
  input  wire logic             reset,
  // Pins
  input  wire logic [WIDTH-1:0] pin_async,
  output logic      [WIDTH-1:0] pin_sync
);

  logic [WIDTH-1:0] stage_one;

  if (WIDTH < 1) begin : g_chk
    $error("fdsr_sync needs at least one bit.");
  end

  // The first stage feeds only the second one.
  always_ff @(posedge ref_clk or posedge reset) begin
    if (reset) begin
      stage_one <= RESET_VAL;
      pin_sync  <= RESET_VAL;
    end else begin
      stage_one <= pin_async;
      pin_sync  <= stage_one;
    end
  end

endmodule

// >>> tb_fdsr_regs.sv
// Self-checking bench for the floppy status and output register bank.
`timescale 1ns/100ps
module tb_fdsr_regs;
  import fdsr_pkg::*;
  logic        ref_clk = 1'b0, reset = 1'b1, io_read_n = 1'b1, io_write_n = 1'b1, rd_pulse = 1'b0;
  logic        core_irq = 1'b0, core_dma_req = 1'b0, core_step = 1'b0, core_direction_in = 1'b1;
  logic        head_side_select = 1'b1, write_gate_out = 1'b0, core_write_data = 1'b0;
  logic        dma_ack_n = 1'b0, dma_tc = 1'b1, io_data_oe, oe, soft_reset_n, dma_irq_enable;
  logic        floppy_irq_out, floppy_irq_oe, dma_req_out, dma_req_oe, dma_ack_n_gated, dma_tc_gated;
  logic        second_drive_present_n, track_zero_n, index_pulse_n, write_protect_n, read_data_n;
  logic [3:0]  drive_select_out_n, motor_on_out_n, pins_n = 4'hF;
  logic [7:0]  io_data_in = 8'h00, io_data_out, rd;
  logic [15:0] io_addr = 16'h0000;
  fdsr_mode_e  status_mode = FDSR_MODE_FULL;
  int          miscompares = 0, check_count = 0;
  fdsr_regs dut (
    .ref_clk(ref_clk), .reset(reset), .status_mode(status_mode), .io_addr(io_addr),
    .io_read_n(io_read_n), .io_write_n(io_write_n), .io_data_in(io_data_in), .io_data_out(io_data_out),
    .io_data_oe(io_data_oe), .second_drive_present_n(second_drive_present_n), .track_zero_n(track_zero_n),
    .index_pulse_n(index_pulse_n), .write_protect_n(write_protect_n), .read_data_n(read_data_n),
    .core_irq(core_irq), .core_dma_req(core_dma_req), .core_step(core_step),
    .core_direction_in(core_direction_in), .head_side_select(head_side_select),
    .write_gate_out(write_gate_out), .core_write_data(core_write_data), .dma_ack_n(dma_ack_n),
    .dma_tc(dma_tc), .drive_select_out_n(drive_select_out_n), .motor_on_out_n(motor_on_out_n),
    .soft_reset_n(soft_reset_n), .dma_irq_enable(dma_irq_enable), .floppy_irq_out(floppy_irq_out),
    .floppy_irq_oe(floppy_irq_oe), .dma_req_out(dma_req_out), .dma_req_oe(dma_req_oe),
    .dma_ack_n_gated(dma_ack_n_gated), .dma_tc_gated(dma_tc_gated));
  fdsr_drive_model drive (
    .ref_clk(ref_clk), .pins_n(pins_n), .rd_pulse(rd_pulse),
    .second_drive_present_n(second_drive_present_n), .track_zero_n(track_zero_n),
    .index_pulse_n(index_pulse_n), .write_protect_n(write_protect_n), .read_data_n(read_data_n));
  initial begin
    forever #4 ref_clk = ~ref_clk;
  end
  task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
    check_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask
  task automatic cyc(int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask
  task automatic wr(logic [15:0] a, logic [7:0] d);
    @(posedge ref_clk);
    io_addr <= a;
    io_data_in <= d;
    io_write_n <= 1'b0;
    @(posedge ref_clk);
    io_write_n <= 1'b1;
  endtask
  task automatic rdx(logic [15:0] a);
    @(posedge ref_clk);
    io_addr <= a;
    io_read_n <= 1'b0;
    cyc(1);
    rd = io_data_out;
    oe = io_data_oe;
    @(posedge ref_clk);
    io_read_n <= 1'b1;
  endtask
  task automatic rdc(string n, logic [15:0] a, logic [7:0] e);
    rdx(a);
    chk(n, {7'h0, oe}, 8'h01);
    chk(n, rd, e);
  endtask
  task automatic pulse_data(logic wd);
    @(posedge ref_clk);
    rd_pulse <= 1'b1;
    core_write_data <= wd;
    repeat (2) @(posedge ref_clk);
    rd_pulse <= 1'b0;
    core_write_data <= 1'b0;
    cyc(6);
  endtask
  function automatic logic [7:0] dma_pins();
    return {1'b0, floppy_irq_out, dma_req_out, dma_irq_enable, floppy_irq_oe, dma_req_oe, dma_ack_n_gated,
            dma_tc_gated};
  endfunction
  task automatic test_reset_and_table();
    logic [7:0] v [4] = '{8'h1C, 8'h2D, 8'h4E, 8'h8F};
    rdc("ctrl reset", OFF_OUTPUT_CTRL, 8'h00);
    rdc("first reset", OFF_STATUS_FIRST, 8'h56);
    rdc("second reset", OFF_STATUS_SECOND, 8'hC0);
    for (int i = 0; i < 4; i++) begin
      wr(OFF_OUTPUT_CTRL, v[i]);
      cyc(2);
      chk("select", {4'h0, drive_select_out_n}, {4'h0, ~(4'h1 << i)});
      chk("motor", {4'h0, motor_on_out_n}, {4'h0, ~(4'h1 << i)});
      rdc("ctrl", OFF_OUTPUT_CTRL, v[i]);
      rdc("second", OFF_STATUS_SECOND, {2'h3, i[0], 3'h0, i == 1, i == 0});
    end
    $display("test_reset_and_table done");
  endtask
  task automatic test_soft_reset();
    int n;
    wr(OFF_OUTPUT_CTRL, 8'h1A);
    wr(OFF_OUTPUT_CTRL, 8'h1E);
    cyc(1);
    chk("soft low", {7'h0, soft_reset_n}, 8'h00);
    n = 0;
    while (soft_reset_n !== 1'b1 && n < 40) begin
      cyc(1);
      n++;
    end
    chk("stretch", {7'h0, n >= SOFT_RESET_CYCLES - 1 && n < 40}, 8'h01);
    rdc("ctrl kept", OFF_OUTPUT_CTRL, 8'h1E);
    rdc("second kept", OFF_STATUS_SECOND, 8'hC1);
    $display("test_soft_reset done");
  endtask
  task automatic test_full_status();
    @(posedge ref_clk);
    pins_n <= 4'h5;
    core_irq <= 1'b1;
    core_step <= 1'b1;
    cyc(6);
    wr(OFF_STATUS_FIRST, 8'h00);
    wr(OFF_STATUS_SECOND, 8'hFF);
    rdc("first full", OFF_STATUS_FIRST, 8'hBB);
    rdc("second ro", OFF_STATUS_SECOND, 8'hC1);
    pulse_data(1'b1);
    rdc("toggles", OFF_STATUS_SECOND, 8'hD9);
    pulse_data(1'b0);
    rdc("toggle back", OFF_STATUS_SECOND, 8'hD1);
    $display("test_full_status done");
  endtask
  task automatic test_alt_status();
    @(posedge ref_clk);
    status_mode <= FDSR_MODE_ALT;
    rdx(OFF_DIGITAL_INPUT);
    rdc("first alt", OFF_STATUS_FIRST, 8'h84);
    rdc("second alt", OFF_STATUS_SECOND, 8'h62);
    @(posedge ref_clk);
    core_step <= 1'b0;
    @(posedge ref_clk);
    core_step <= 1'b1;
    core_dma_req <= 1'b1;
    write_gate_out <= 1'b1;
    pulse_data(1'b1);
    rdc("step latched", OFF_STATUS_FIRST, 8'hE4);
    rdc("flags latched", OFF_STATUS_SECOND, 8'h7E);
    rdx(OFF_DIGITAL_INPUT);
    rdc("step cleared", OFF_STATUS_FIRST, 8'hC4);
    rdc("flags cleared", OFF_STATUS_SECOND, 8'h62);
    $display("test_alt_status done");
  endtask
  task automatic test_legacy_dma();
    @(posedge ref_clk);
    status_mode <= FDSR_MODE_LEGACY;
    cyc(3);
    chk("pins on", dma_pins(), 8'h7D);
    wr(OFF_OUTPUT_CTRL, 8'h16);
    cyc(3);
    chk("pins off", dma_pins(), 8'h62);
    rdx(OFF_STATUS_FIRST);
    chk("first hiz", {7'h0, oe}, 8'h00);
    rdx(OFF_STATUS_SECOND);
    chk("second hiz", {7'h0, oe}, 8'h00);
    @(posedge ref_clk);
    status_mode <= FDSR_MODE_FULL;
    cyc(3);
    chk("pins full", dma_pins(), 8'h7D);
    @(posedge ref_clk);
    reset <= 1'b1;
    cyc(2);
    chk("pins in reset", dma_pins(), 8'h1D);
    @(posedge ref_clk);
    reset <= 1'b0;
    rdc("ctrl hw reset", OFF_OUTPUT_CTRL, 8'h00);
    $display("test_legacy_dma done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", check_count, miscompares);
    if (miscompares == 0 && check_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask
  // The tests take well under 1000 cycles, so 50 us leaves a wide margin.
  initial begin
    #50000;
    miscompares++;
    report_and_stop();
  end
  initial begin
    repeat (8) @(posedge ref_clk);
    reset <= 1'b0;
    test_reset_and_table();
    test_soft_reset();
    test_full_status();
    test_alt_status();
    test_legacy_dma();
    report_and_stop();
  end
endmodule
bind fdsr_regs fdsr_regs_assertions chk_i (
  .ref_clk(ref_clk), .reset(reset), .status_mode(status_mode), .io_addr(io_addr),
  .io_read_n(io_read_n), .io_write_n(io_write_n), .io_data_in(io_data_in), .io_data_out(io_data_out),
  .io_data_oe(io_data_oe), .drive_select_out_n(drive_select_out_n), .motor_on_out_n(motor_on_out_n),
  .soft_reset_n(soft_reset_n), .dma_irq_enable(dma_irq_enable), .floppy_irq_oe(floppy_irq_oe),
  .dma_req_oe(dma_req_oe), .dma_ack_n_gated(dma_ack_n_gated), .dma_tc_gated(dma_tc_gated));
